/* File: common/ppt_pkg.sv */
// Package: register map, field layout and bus types for the PWM control block
//
// Operation
// R1: The polarity setting is double-buffered and, while halted, reaches the pin on the next input clock edge.
// R2: While running, a new polarity takes effect only at a cycle boundary so the pin never glitches.
// R3: With invert clear, each cycle drives high for the high-time count, then low for period minus high-time.
// R4: With invert set, each cycle drives low first and then high, with the same two durations.
// R5: Halted and disabled, the pin holds high when invert is 1 and low when it is 0, low after reset.
// R6: The invert bit resets to 0, non-inverted, and writing 1 selects inverted output.
// R7: A mode bit selects normal or triggered start, normal after reset.
// R8: In normal mode output begins as soon as the channel is enabled.
// R9: In triggered mode an enabled channel waits for a rising edge on the trigger pin.
// R10: Once triggered, cycles continue even when the trigger pin returns low.
// R11: Clearing enable lets the cycle in progress finish and then halts.
// R12: Channel 1 has its own 16-bit period register that behaves like channel 0's.
// R13: Software writes reserved bits of the polarity and mode registers as zero.
// R14: At each cycle start the buffered period and high-time load into down-counters.
// R15: Setting enable copies period and high-time into the counters and output starts on the next edge.
// R16: The trigger pin passes two flip-flops before rising-edge detection.
package ppt_pkg;

    // ========================================================================
    // Register offsets (byte addresses)
    localparam logic [5:0] OFS_CH0_PERIOD   = 6'h00;
    localparam logic [5:0] OFS_CH0_HIGH     = 6'h04;
    localparam logic [5:0] OFS_CH0_ENABLE   = 6'h08;
    localparam logic [5:0] OFS_CH0_POLARITY = 6'h0c;
    localparam logic [5:0] OFS_CH0_TRIGMODE = 6'h10;
    localparam logic [5:0] OFS_CH1_PERIOD   = 6'h20;

    // ========================================================================
    // Field layout and reset values
    localparam int          CNT_W        = 16;
    localparam int          BIT_ENABLE   = 0;
    localparam int          BIT_INVERT   = 0;
    localparam int          BIT_MODE     = 0;
    localparam logic [15:0] RST_COUNT    = 16'h0000;
    localparam logic        RST_BIT      = 1'b0;
    localparam logic [15:0] ONE_COUNT    = 16'h0001;
    localparam logic [31:0] RDATA_ZERO   = 32'h0000_0000;

    // ========================================================================
    // Types
    typedef enum logic {PPT_PH_HIGH, PPT_PH_LOW} ppt_phase_e;

    typedef struct packed {
        logic [5:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } ppt_bus_req_s;

endpackage : ppt_pkg

/* File: hw/ppt_channel.sv */
// Module: polarity, trigger start and cycle generation for one PWM channel
//
// Added by the designer: the Avalon-MM interface to the registers.
module ppt_channel #(
    parameter int CNT_W = ppt_pkg::CNT_W
) (
    input  wire logic                 clk_sys_i,
    input  wire logic                 nrst_i,
    input  wire ppt_pkg::ppt_bus_req_s bus_i,
    output logic                      waitrequest_o,
    output logic [31:0]               readdata_o,
    output logic                      readdatavalid_o,
    input  wire logic                 ch0_trigger_input_i,
    output logic                      ch0_pwm_o,
    output logic                      ch0_running_o
);

    // Counters and the merge helper serve at most 16 bits
    if (CNT_W < 2 || CNT_W > 16)
    begin : g_bad_cnt_w
        $error("CNT_W must lie between 2 and 16");
    end

    // ========================================================================
    // Register file
    logic [CNT_W-1:0] ch0_period_reg;
    logic [CNT_W-1:0] ch0_high_time_reg;
    logic [CNT_W-1:0] ch1_period_reg;
    logic             ch0_enable_reg;
    logic             ch0_polarity_reg;
    logic             ch0_mode_reg;
    logic             answered_reg;
    logic             waitrequest_reg;
    logic [31:0]      readdata_reg;

    wire req_w   = bus_i.read | bus_i.write;
    // One wait cycle: request is taken on the second edge it is held
    wire take_w  = req_w & answered_reg;
    // Read data are latched one edge early so they stand at the taking edge
    wire rd_early_w = req_w & ~answered_reg & bus_i.read;
    wire wr_w    = take_w & bus_i.write & bus_i.byteenable[0];
    wire wr_hi_w = take_w & bus_i.write & bus_i.byteenable[1];
    wire sel_p0  = bus_i.address == ppt_pkg::OFS_CH0_PERIOD;
    wire sel_h0  = bus_i.address == ppt_pkg::OFS_CH0_HIGH;
    wire sel_en  = bus_i.address == ppt_pkg::OFS_CH0_ENABLE;
    wire sel_pol = bus_i.address == ppt_pkg::OFS_CH0_POLARITY;
    wire sel_md  = bus_i.address == ppt_pkg::OFS_CH0_TRIGMODE;
    wire sel_p1  = bus_i.address == ppt_pkg::OFS_CH1_PERIOD;

    function automatic logic [CNT_W-1:0] merge(input logic [CNT_W-1:0] old,
                                                input logic [31:0] d,
                                                input logic lo,
                                                input logic hi);
        logic [15:0] o16;
        o16 = 16'(old);
        if (lo)
            o16[7:0] = d[7:0];
        if (hi)
            o16[15:8] = d[15:8];
        return CNT_W'(o16);
    endfunction

    logic [31:0] rd_mux_w;
    assign rd_mux_w = sel_p0  ? 32'(ch0_period_reg)
                    : sel_h0  ? 32'(ch0_high_time_reg)
                    : sel_en  ? 32'(ch0_enable_reg)
                    : sel_pol ? 32'(ch0_polarity_reg)
                    : sel_md  ? 32'(ch0_mode_reg)
                    : sel_p1  ? 32'(ch1_period_reg)
                    : ppt_pkg::RDATA_ZERO;

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            answered_reg    <= 1'b0;
            waitrequest_reg <= 1'b1;
        end
        else
        begin
            answered_reg    <= req_w & ~answered_reg;
            waitrequest_reg <= ~(req_w & ~answered_reg);
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            ch0_period_reg    <= CNT_W'(ppt_pkg::RST_COUNT);
            ch0_high_time_reg <= CNT_W'(ppt_pkg::RST_COUNT);
            ch1_period_reg    <= CNT_W'(ppt_pkg::RST_COUNT);
            ch0_enable_reg    <= ppt_pkg::RST_BIT;
            ch0_polarity_reg  <= ppt_pkg::RST_BIT;   // [R6]
            ch0_mode_reg      <= ppt_pkg::RST_BIT;   // [R7]
            readdata_reg      <= ppt_pkg::RDATA_ZERO;
            readdatavalid_o   <= 1'b0;
        end
        else
        begin
            if (sel_p0)
                ch0_period_reg <= merge(ch0_period_reg, bus_i.writedata,
                                        wr_w, wr_hi_w);
            if (sel_h0)
                ch0_high_time_reg <= merge(ch0_high_time_reg,
                                           bus_i.writedata, wr_w, wr_hi_w);
            if (sel_p1)
                ch1_period_reg <= merge(ch1_period_reg, bus_i.writedata,
                                        wr_w, wr_hi_w);   // [R12]
            if (wr_w && sel_en)
                ch0_enable_reg <= bus_i.writedata[ppt_pkg::BIT_ENABLE];
            if (wr_w && sel_pol)
                ch0_polarity_reg <= bus_i.writedata[ppt_pkg::BIT_INVERT];
            if (wr_w && sel_md)
                ch0_mode_reg <= bus_i.writedata[ppt_pkg::BIT_MODE];
            readdatavalid_o <= rd_early_w;
            if (rd_early_w)
                readdata_reg <= rd_mux_w;
        end
    end

    assign waitrequest_o = waitrequest_reg;
    assign readdata_o    = readdata_reg;

    // ========================================================================
    // Trigger synchroniser and edge detect
    logic trig_s1_reg;
    logic trig_s2_reg;
    logic trig_s3_reg;

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            trig_s1_reg <= 1'b0;
            trig_s2_reg <= 1'b0;
            trig_s3_reg <= 1'b0;
        end
        else
        begin
            trig_s1_reg <= ch0_trigger_input_i;   // [R16]
            trig_s2_reg <= trig_s1_reg;
            trig_s3_reg <= trig_s2_reg;
        end
    end

    wire trig_rise_w = trig_s2_reg & ~trig_s3_reg;   // [R16]

    // ========================================================================
    // Cycle engine
    logic                ch0_running_reg;
    ppt_pkg::ppt_phase_e phase_reg;
    ppt_pkg::ppt_phase_e phase_next;
    logic [CNT_W-1:0]    high_cnt_reg;
    logic [CNT_W-1:0]    low_cnt_reg;
    logic                inv_active_reg;
    logic                pwm_reg;

    // Start permitted by mode; trigger waits for a rising edge only
    wire start_ok_w = ~ch0_mode_reg | trig_rise_w;   // [R8] [R9]
    wire start_w    = ~ch0_running_reg & ch0_enable_reg & start_ok_w; // [R15]
    wire cyc_end_w  = ch0_running_reg & (phase_reg == ppt_pkg::PPT_PH_LOW)
                    & (low_cnt_reg <= CNT_W'(ppt_pkg::ONE_COUNT));
    wire high_end_w = (phase_reg == ppt_pkg::PPT_PH_HIGH)
                    & (high_cnt_reg <= CNT_W'(ppt_pkg::ONE_COUNT));
    // A cycle boundary restarts only while enable stays set
    wire again_w    = cyc_end_w & ch0_enable_reg;   // [R10] [R11]
    wire load_w     = start_w | again_w;            // [R14]
    wire [CNT_W-1:0] low_len_w = ch0_period_reg - ch0_high_time_reg;
    // Polarity follows software while halted, latches only at a boundary
    wire inv_next_w = (load_w | ~ch0_running_reg) ? ch0_polarity_reg
                    : inv_active_reg;               // [R1] [R2]
    wire active_hi_w = load_w ? (ch0_high_time_reg != '0)
                     : (phase_next == ppt_pkg::PPT_PH_HIGH);

    always_comb
    begin
        phase_next = phase_reg;
        if (load_w)
            phase_next = ppt_pkg::PPT_PH_HIGH;
        else if (ch0_running_reg && high_end_w)
            phase_next = ppt_pkg::PPT_PH_LOW;
    end

    wire running_next_w = load_w | (ch0_running_reg & ~cyc_end_w);

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            ch0_running_reg <= 1'b0;
            phase_reg       <= ppt_pkg::PPT_PH_HIGH;
            high_cnt_reg    <= CNT_W'(ppt_pkg::RST_COUNT);
            low_cnt_reg     <= CNT_W'(ppt_pkg::RST_COUNT);
            inv_active_reg  <= ppt_pkg::RST_BIT;
            pwm_reg         <= 1'b0;   // [R5]
        end
        else
        begin
            ch0_running_reg <= running_next_w;
            phase_reg       <= phase_next;
            inv_active_reg  <= inv_next_w;
            if (load_w)
            begin
                high_cnt_reg <= ch0_high_time_reg;   // [R14]
                low_cnt_reg  <= low_len_w;
            end
            else if (ch0_running_reg && phase_reg == ppt_pkg::PPT_PH_HIGH
                     && !high_end_w)
                high_cnt_reg <= high_cnt_reg - CNT_W'(ppt_pkg::ONE_COUNT);
            else if (ch0_running_reg && phase_reg == ppt_pkg::PPT_PH_LOW)
                low_cnt_reg <= low_cnt_reg - CNT_W'(ppt_pkg::ONE_COUNT);
            if (running_next_w)
                pwm_reg <= active_hi_w ^ inv_next_w;   // [R3] [R4]
            else
                pwm_reg <= inv_next_w;                 // [R5]
        end
    end

    assign ch0_pwm_o     = pwm_reg;
    assign ch0_running_o = ch0_running_reg;

    // ========================================================================
    // Checks
    sequence s_enable_normal;
        ch0_enable_reg && !ch0_mode_reg && !ch0_running_reg;
    endsequence

    normal_start_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        s_enable_normal |=> ch0_running_reg) // [R8]
        else $error("normal mode did not start at once");

    trig_wait_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (!ch0_running_reg && ch0_mode_reg && !trig_rise_w) |=> !ch0_running_reg) // [R9]
        else $error("triggered mode started without an edge");

    halt_level_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (!ch0_running_reg && $past(!ch0_running_reg) && $stable(ch0_polarity_reg))
        |-> pwm_reg == ch0_polarity_reg) // [R5]
        else $error("halted level does not follow polarity");

    halted_pol_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (!running_next_w && !ch0_running_reg) |=> pwm_reg == $past(ch0_polarity_reg)) // [R1]
        else $error("halted polarity not applied at next edge");

    glitch_free_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (ch0_running_reg && !load_w && running_next_w) |=> $stable(inv_active_reg)) // [R2]
        else $error("polarity changed mid cycle");

    finish_cycle_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (ch0_running_reg && !cyc_end_w) |=> ch0_running_reg) // [R11]
        else $error("cycle stopped before its end");

    keep_going_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (cyc_end_w && ch0_enable_reg) |=> ch0_running_reg) // [R10]
        else $error("running channel stopped while enabled");

    load_count_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        load_w |=> high_cnt_reg == $past(ch0_high_time_reg)
                   && low_cnt_reg == $past(low_len_w)) // [R14]
        else $error("counters not loaded at cycle start");

    level_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (ch0_running_reg && phase_reg == ppt_pkg::PPT_PH_LOW)
        |-> pwm_reg == inv_active_reg) // [R3] [R4]
        else $error("second phase level wrong");

endmodule : ppt_channel

/* File: verif/ppt_trig_src.sv */
// Partner model: external trigger source driving the channel's trigger pin
module ppt_trig_src (
    input  wire logic       clk_sys_i,
    input  wire logic       fire_i,
    input  wire logic [2:0] width_i,
    output logic            trig_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [2:0] left_reg;

    initial
    begin
        trig_o   = 1'b0;
        left_reg = 3'h0;
    end

    // ========================================================================
    // Pulse
    // A pulse of width_i cycles that falls again before or while the channel runs
    always @(posedge clk_sys_i)
    begin
        if (fire_i && left_reg == 3'h0)
        begin
            trig_o   <= 1'b1;
            left_reg <= width_i;
        end
        else if (left_reg > 3'h1)
            left_reg <= left_reg - 3'h1;
        else
        begin
            trig_o   <= 1'b0;
            left_reg <= 3'h0;
        end
    end
endmodule // ppt_trig_src

/* File: verif/tb_ppt_channel.sv */
// Self-checking testbench for the PWM polarity and trigger channel
module tb_ppt_channel;
    timeunit 1ns;
    timeprecision 1ps;

    logic                  clk_sys_i = 1'b0;
    logic                  nrst_i    = 1'b0;
    logic                  fire      = 1'b0;
    logic [2:0]            width     = 3'h1;
    logic                  trig;
    ppt_pkg::ppt_bus_req_s bus_req   = '{6'h00, 1'b0, 1'b0, 32'h0, 4'hf};
    logic                  waitrequest_o;
    logic                  readdatavalid_o;
    logic                  ch0_pwm_o;
    logic                  ch0_running_o;
    logic [31:0]           readdata_o;
    logic [15:0]           v;
    logic [31:0]           rd_q[$];
    logic                  pin_q[$];
    int                    fail_count = 0;
    int                    n_tests    = 0;
    int                    cyc        = 0;
    int                    seed       = 97296;
    int                    k;

    always #50 clk_sys_i = ~clk_sys_i;

    ppt_channel uut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .bus_i(bus_req),
        .waitrequest_o(waitrequest_o), .readdata_o(readdata_o),
        .readdatavalid_o(readdatavalid_o), .ch0_trigger_input_i(trig),
        .ch0_pwm_o(ch0_pwm_o), .ch0_running_o(ch0_running_o));
    ppt_trig_src partner (.clk_sys_i(clk_sys_i), .fire_i(fire),
        .width_i(width), .trig_o(trig));

    // ========================================================================
    // Checking and verdict
    task check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task tally_and_finish;
        $display("Checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(posedge clk_sys_i)
    begin
        cyc++;
        if (cyc > 5000)
        begin
            fail_count++;
            tally_and_finish();
        end
    end

    // Watchers pop the oldest expectation when a result appears
    always @(posedge clk_sys_i)
        if (readdatavalid_o === 1'b1 && rd_q.size() > 0)
            check(readdata_o, rd_q.pop_front());
    always @(negedge clk_sys_i)
        if (pin_q.size() > 0)
            check({31'h0, ch0_pwm_o}, {31'h0, pin_q.pop_front()});

    // ========================================================================
    // Bus and expectation helpers
    // Reserved upper bits always written as zero
    task xfer(input logic rd, input logic [5:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        bus_req.read      <= rd;
        bus_req.write     <= ~rd;
        bus_req.address   <= a;
        bus_req.writedata <= {16'h0000, d};
        do @(posedge clk_sys_i); while (waitrequest_o !== 1'b0);
        bus_req.read  <= 1'b0;
        bus_req.write <= 1'b0;
    endtask

    task rd(input logic [5:0] a, input logic [15:0] e);
        rd_q.push_back({16'h0000, e});
        xfer(1'b1, a, 16'h0000);
    endtask

    task push_lvl(input logic lv, input int n);
        repeat (n) pin_q.push_back(lv);
    endtask

    task push_wave(input logic output_invert, input int per, input int hi, input int n);
        repeat (n)
        begin
            push_lvl(~output_invert, hi);
            push_lvl(output_invert, per - hi);
        end
    endtask

    task drain;
        while (pin_q.size() > 0) @(posedge clk_sys_i);
    endtask

    task halt;
        xfer(1'b0, ppt_pkg::OFS_CH0_ENABLE, 16'h0000);
        while (ch0_running_o !== 1'b0) @(posedge clk_sys_i);
    endtask

    // ========================================================================
    // Main sequence
    initial
    begin
        repeat (3) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        rd(ppt_pkg::OFS_CH0_POLARITY, 16'h0000);
        rd(ppt_pkg::OFS_CH0_TRIGMODE, 16'h0000);
        rd(ppt_pkg::OFS_CH1_PERIOD, 16'h0000);
        push_lvl(1'b0, 4);
        v = 16'($random(seed));
        xfer(1'b0, ppt_pkg::OFS_CH1_PERIOD, v);
        rd(ppt_pkg::OFS_CH1_PERIOD, v);
        rd(6'h3c, 16'h0000);
        xfer(1'b0, ppt_pkg::OFS_CH0_PERIOD, 16'h0006);
        xfer(1'b0, ppt_pkg::OFS_CH0_HIGH, 16'h0004);
        drain();
        // Disable lands mid-cycle: the cycle must still complete
        xfer(1'b0, ppt_pkg::OFS_CH0_ENABLE, 16'h0001);
        push_lvl(1'b0, 1);
        push_wave(1'b0, 6, 4, 1);
        push_lvl(1'b0, 4);
        xfer(1'b0, ppt_pkg::OFS_CH0_ENABLE, 16'h0000);
        drain();
        xfer(1'b0, ppt_pkg::OFS_CH0_POLARITY, 16'h0001);
        push_lvl(1'b0, 1);
        push_lvl(1'b1, 3);
        drain();
        // Polarity and high time change while running apply next cycle
        xfer(1'b0, ppt_pkg::OFS_CH0_ENABLE, 16'h0001);
        push_lvl(1'b1, 1);
        push_wave(1'b1, 6, 4, 1);
        push_wave(1'b0, 6, 2, 2);
        xfer(1'b0, ppt_pkg::OFS_CH0_POLARITY, 16'h0000);
        xfer(1'b0, ppt_pkg::OFS_CH0_HIGH, 16'h0002);
        drain();
        halt();
        xfer(1'b0, ppt_pkg::OFS_CH0_TRIGMODE, 16'h0001);
        xfer(1'b0, ppt_pkg::OFS_CH0_ENABLE, 16'h0001);
        push_lvl(1'b0, 8);
        drain();
        width <= 3'(1 + {$random(seed)} % 7);
        fire  <= 1'b1;
        @(posedge clk_sys_i);
        fire <= 1'b0;
        k = 0;
        do
        begin
            @(posedge clk_sys_i);
            #1;
            k++;
        end while (ch0_running_o !== 1'b1 && k < 8);
        check(32'(k >= 3 && k < 8), 32'h0000_0001);
        push_wave(1'b0, 6, 2, 3);
        drain();
        halt();
        tally_and_finish();
    end
endmodule // tb_ppt_channel
